// file: lcdpp_pkg.sv
// shared constants, register map and helpers for the polarity and pump clock generator
package lcdpp_pkg;
    // apb register byte offsets
    localparam logic [11:0] LCDPP_CTRL_OFF    = 12'h000;
    localparam logic [11:0] LCDPP_STATUS_OFF  = 12'h004;
    localparam logic [11:0] LCDPP_LINES_OFF   = 12'h008;
    localparam logic [11:0] LCDPP_FLIPS_OFF   = 12'h00C;

    // ctrl fields
    localparam int          LCDPP_CTRL_SOFT_OFF = 0;
    localparam int          LCDPP_CTRL_OVR_EN   = 1;
    localparam int          LCDPP_CTRL_OVR_LSB  = 4;
    localparam logic [7:0]  LCDPP_CTRL_RESET    = 8'h00;
    localparam logic [7:0]  LCDPP_CTRL_MASK     = 8'hF3;

    // status fields
    localparam int          LCDPP_ST_POLARITY   = 0;
    localparam int          LCDPP_ST_PUMP_RUN   = 1;
    localparam int          LCDPP_ST_DISCHARGE  = 2;
    localparam int          LCDPP_ST_MODE_6X    = 3;
    localparam int          LCDPP_ST_LINE_LOST  = 4;
    localparam int          LCDPP_ST_IVL_LSB    = 8;

    // interval range in line periods
    localparam logic [4:0]  LCDPP_IVL_OFFSET    = 5'h02;
    localparam logic [4:0]  LCDPP_IVL_MAX       = 5'h11;

    // missing line pulse watchdog
    localparam int          LCDPP_CLK_MHZ       = 100;
    localparam int          LCDPP_LOST_TIME_US  = 1000;
    localparam int          LCDPP_LOST_CYC      = LCDPP_LOST_TIME_US * LCDPP_CLK_MHZ;

    typedef enum logic {
        LCDPP_MODE_5X,
        LCDPP_MODE_6X
    } lcdpp_mode_e;

    // line periods between reversals for a 4 bit setting
    function automatic logic [4:0] lcdpp_interval_lines(input logic [3:0] sel);
        return {1'b0, sel} + LCDPP_IVL_OFFSET;
    endfunction : lcdpp_interval_lines
endpackage : lcdpp_pkg

// file: lcdpp_polarity.sv
// frame polarity generator counting line pulses
`timescale 1ns/1ps
module lcdpp_polarity
    import lcdpp_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       line_edge,
    input  wire logic [3:0] interval_sel,
    output logic            polarity_r,
    output logic            flip_pulse
);
    logic [4:0] cnt_r;
    logic [4:0] limit;

    assign limit      = lcdpp_interval_lines(interval_sel);
    // >= keeps the count bounded when the setting shrinks mid interval
    assign flip_pulse = line_edge && (cnt_r + 5'h01 >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 5'h00;
        end else if (flip_pulse) begin
            cnt_r <= 5'h00;
        end else if (line_edge) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            polarity_r <= 1'b0;
        end else if (flip_pulse) begin
            polarity_r <= ~polarity_r;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_flip_at_limit: assert property (line_edge && cnt_r + 5'h01 == limit |=> polarity_r != $past(polarity_r))
        else $error("polarity did not reverse at interval end");
    chk_hold_mid_ivl: assert property (!(line_edge && cnt_r + 5'h01 >= limit) |=> $stable(polarity_r))
        else $error("polarity changed inside interval");
    chk_count_bound: assert property (cnt_r < LCDPP_IVL_MAX)
        else $error("line count exceeded longest interval");
endmodule : lcdpp_polarity

// file: lcdpp_pump_clk.sv
// charge pump clock derived from line pulses with stop control
`timescale 1ns/1ps
module lcdpp_pump_clk
    import lcdpp_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic line_edge,
    input  wire logic pump_enable,
    output logic      pump_clk_r,
    output logic      pump_run_r
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_clk_r <= 1'b0;
        end else if (!pump_enable) begin
            pump_clk_r <= 1'b0;
        end else if (line_edge) begin
            pump_clk_r <= ~pump_clk_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_run_r <= 1'b0;
        end else begin
            pump_run_r <= pump_enable;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_pump_stops: assert property (!pump_enable |=> !pump_clk_r && !pump_run_r)
        else $error("pump clock ran while stopped");
    chk_pump_src: assert property ($changed(pump_clk_r) && $past(pump_enable) |-> $past(line_edge))
        else $error("pump clock moved without a line pulse");
endmodule : lcdpp_pump_clk

// file: lcdpp_top.sv
// polarity and charge pump timing generator with apb control
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps

//Contract
// - polarity timing uses only the incoming line pulse, one line as unit.
// - four select inputs set reversal interval from 2 to 17 lines.
// - inverted polarity output is always the exact complement of polarity.
// - pump clock is derived from line pulses, no free oscillator.
// - display off low stops pump clock and all conversion activity.
// - two step-up modes: five times and six times.
// - power off or display off enables row negative rail discharge.
// - mode pin low gives five times, high gives six times.
module lcdpp_top
    import lcdpp_pkg::*;
#(
    parameter int LOST_CYC = LCDPP_LOST_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        line_pulse,
    input  wire logic [3:0]  interval_select,
    input  wire logic        display_off_n,
    input  wire logic        pump_mode_select,
    output logic             polarity_out,
    output logic             polarity_out_n,
    output logic             pump_clk,
    output logic             pump_run,
    output logic             pump_mode_6x,
    output logic             row_negative_rail_discharge
);
    logic        line_d_r;
    logic        line_edge;
    logic [7:0]  ctrl_r;
    logic [3:0]  interval_eff;
    logic        pump_enable;
    logic        polarity_r;
    logic        flip_pulse;
    logic        pump_clk_r;
    logic        pump_run_r;
    lcdpp_mode_e mode_r;
    logic        discharge_r;
    logic        line_lost_r;
    logic [31:0] lost_cnt_r;
    logic [31:0] lines_r;
    logic [31:0] flips_r;
    logic [31:0] prdata_r;
    logic        setup;
    logic        access;
    logic        wr_ok;
    logic        addr_hit;
    logic        addr_ro;
    logic [31:0] status_word;
    logic        clear_lost;

    // line pulse is synchronous; act on its rising edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_d_r <= 1'b0;
        end else begin
            line_d_r <= line_pulse;
        end
    end
    assign line_edge = line_pulse && !line_d_r;

    assign interval_eff = ctrl_r[LCDPP_CTRL_OVR_EN] ? ctrl_r[LCDPP_CTRL_OVR_LSB +: 4] : interval_select;
    // software off acts like the display off pin
    assign pump_enable  = display_off_n && !ctrl_r[LCDPP_CTRL_SOFT_OFF];

    lcdpp_polarity u_polarity (
        .pclk         (pclk),
        .presetn      (presetn),
        .line_edge    (line_edge),
        .interval_sel (interval_eff),
        .polarity_r   (polarity_r),
        .flip_pulse   (flip_pulse)
    );

    lcdpp_pump_clk u_pump_clk (
        .pclk         (pclk),
        .presetn      (presetn),
        .line_edge    (line_edge),
        .pump_enable  (pump_enable),
        .pump_clk_r   (pump_clk_r),
        .pump_run_r   (pump_run_r)
    );

    assign polarity_out   = polarity_r;
    assign polarity_out_n = ~polarity_r;
    assign pump_clk       = pump_clk_r;
    assign pump_run       = pump_run_r;

    // mode pin is a strap; sampled every cycle after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= LCDPP_MODE_5X;
        end else begin
            mode_r <= pump_mode_select ? LCDPP_MODE_6X : LCDPP_MODE_5X;
        end
    end
    assign pump_mode_6x = (mode_r == LCDPP_MODE_6X);

    // discharge is held during reset so a power-off also bleeds the rail
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            discharge_r <= 1'b1;
        end else begin
            discharge_r <= !pump_enable;
        end
    end
    assign row_negative_rail_discharge = discharge_r;

    // watchdog for a controller that stops sending line pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_cnt_r <= 32'h0000_0000;
        end else if (line_edge) begin
            lost_cnt_r <= 32'h0000_0000;
        end else if (lost_cnt_r < LOST_CYC) begin
            lost_cnt_r <= lost_cnt_r + 32'h0000_0001;
        end
    end

    // sticky; a new timeout beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_lost_r <= 1'b0;
        end else if (lost_cnt_r == LOST_CYC - 1) begin
            line_lost_r <= 1'b1;
        end else if (clear_lost) begin
            line_lost_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lines_r <= 32'h0000_0000;
        end else if (line_edge) begin
            lines_r <= lines_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flips_r <= 32'h0000_0000;
        end else if (flip_pulse) begin
            flips_r <= flips_r + 32'h0000_0001;
        end
    end

    // apb slave: zero wait states, read data latched in the setup cycle
    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign addr_hit = (paddr == LCDPP_CTRL_OFF) || (paddr == LCDPP_STATUS_OFF) ||
                      (paddr == LCDPP_LINES_OFF) || (paddr == LCDPP_FLIPS_OFF);
    assign addr_ro  = (paddr == LCDPP_LINES_OFF) || (paddr == LCDPP_FLIPS_OFF);
    assign pready   = 1'b1;
    assign pslverr  = access && (!addr_hit || (pwrite && addr_ro));
    assign wr_ok    = access && pwrite && addr_hit && !addr_ro;
    assign clear_lost = wr_ok && (paddr == LCDPP_STATUS_OFF) && pstrb[0] && pwdata[LCDPP_ST_LINE_LOST];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[LCDPP_ST_POLARITY]  = polarity_r;
        status_word[LCDPP_ST_PUMP_RUN]  = pump_run_r;
        status_word[LCDPP_ST_DISCHARGE] = discharge_r;
        status_word[LCDPP_ST_MODE_6X]   = pump_mode_6x;
        status_word[LCDPP_ST_LINE_LOST] = line_lost_r;
        status_word[LCDPP_ST_IVL_LSB +: 5] = lcdpp_interval_lines(interval_eff);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= LCDPP_CTRL_RESET;
        end else if (wr_ok && (paddr == LCDPP_CTRL_OFF) && pstrb[0]) begin
            ctrl_r <= pwdata[7:0] & LCDPP_CTRL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                LCDPP_CTRL_OFF:   prdata_r <= {24'h00_0000, ctrl_r};
                LCDPP_STATUS_OFF: prdata_r <= status_word;
                LCDPP_LINES_OFF:  prdata_r <= lines_r;
                LCDPP_FLIPS_OFF:  prdata_r <= flips_r;
                default:          prdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata = prdata_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_pol_complement: assert property (polarity_out_n == !polarity_out)
        else $error("polarity outputs not complementary");
    chk_pol_line_only: assert property ($changed(polarity_out) |-> $past(line_edge))
        else $error("polarity changed without a line pulse");
    chk_mode_follows: assert property (pump_mode_select |=> pump_mode_6x ##0 $past(pump_mode_select))
        else $error("six times mode not selected");
    chk_mode_five: assert property (!pump_mode_select |=> !pump_mode_6x)
        else $error("five times mode not selected");
    chk_off_discharge: assert property (!display_off_n |=> row_negative_rail_discharge && !pump_clk)
        else $error("display off without discharge");
    chk_off_no_pump: assert property (!display_off_n [*2] |-> !pump_run)
        else $error("conversion active while display off");
endmodule : lcdpp_top

// file: lcdpp_line_ctrl.sv
// display controller model issuing one latch pulse per line
`timescale 1ns/1ps
module lcdpp_line_ctrl (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [7:0] period,
    output logic            line_pulse
);
    logic [7:0] tick_r;

    // one high cycle per line, low for the rest of it, so every line is a fresh edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_r     <= 8'h00;
            line_pulse <= 1'b0;
        end else begin
            tick_r     <= (!run || tick_r == period - 8'h01) ? 8'h00 : tick_r + 8'h01;
            line_pulse <= run && (tick_r == 8'h00);
        end
    end
endmodule : lcdpp_line_ctrl

// file: tb_lcdpp_top.sv
// self-checking bench for the polarity and pump clock generator
`timescale 1ns/1ps
module tb_lcdpp_top;
    import lcdpp_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, line_pulse, polarity_out, polarity_out_n;
    logic [31:0] prdata, rd;
    logic        pump_clk, pump_run, pump_mode_6x, row_negative_rail_discharge, err;
    logic [3:0]  interval_select = 4'h0;
    logic        display_off_n = 1'b1;
    logic        pump_mode_select = 1'b0;
    logic        run = 1'b1;
    logic        lp_q = 1'b0, pc_q = 1'b0, pol_q = 1'b0;
    int          bad_count = 0, cmp_count = 0, cycles = 0, flips = 0;
    int          lp_cnt = 0, pt_cnt = 0, seen_lines = 0, seen_pump = 0;
    int          lines_total = 0, f1 = 0;

    always #5 pclk = ~pclk;

    lcdpp_line_ctrl lcdpp_line_ctrl_i (.pclk(pclk), .presetn(presetn), .run(run), .period(8'h06),
                                       .line_pulse(line_pulse));

    lcdpp_top #(.LOST_CYC(50)) lcdpp_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .line_pulse(line_pulse), .interval_select(interval_select),
        .display_off_n(display_off_n), .pump_mode_select(pump_mode_select),
        .polarity_out(polarity_out), .polarity_out_n(polarity_out_n), .pump_clk(pump_clk),
        .pump_run(pump_run), .pump_mode_6x(pump_mode_6x),
        .row_negative_rail_discharge(row_negative_rail_discharge));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // setup then access, held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // first reversal after a change may be short, so judge the second one
    task automatic measure(input logic [3:0] sel, input logic pin_on, input logic on);
        int f0;
        interval_select <= sel;
        display_off_n <= pin_on;
        @(posedge pclk);
        f0 = flips;
        while (flips < f0 + 2) @(posedge pclk);
        chk("lines per reversal", {28'h0, sel} + 32'h2, seen_lines);
        chk("pump toggles", on ? {28'h0, sel} + 32'h2 : 32'h0, seen_pump);
        chk("pump run", {31'h0, on}, {31'h0, pump_run});
        chk("discharge", {31'h0, !on}, {31'h0, row_negative_rail_discharge});
        apb(1'b0, LCDPP_STATUS_OFF, 32'h0);
        chk("status interval", {27'h0, {1'b0, sel} + LCDPP_IVL_OFFSET}, {27'h0, rd[12:8]});
        $display("test interval %0d pin %0d done", sel, pin_on);
    endtask : measure

    // counts seen one edge late, consistently for all three signals
    always @(posedge pclk) begin
        if (line_pulse && !lp_q) begin
            lp_cnt++;
            lines_total++;
        end
        if (pump_clk !== pc_q) pt_cnt++;
        if (polarity_out !== pol_q) begin
            seen_lines = lp_cnt;
            seen_pump = pt_cnt;
            lp_cnt = 0;
            pt_cnt = 0;
            flips++;
        end
        lp_q = line_pulse;
        pc_q = pump_clk;
        pol_q = polarity_out;
    end

    always @(negedge pclk) begin
        if (polarity_out_n !== ~polarity_out) chk("inverse polarity", {31'h0, ~polarity_out}, {31'h0, polarity_out_n});
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (10) @(posedge pclk);
        chk("reset polarity", 32'h0, {31'h0, polarity_out});
        chk("reset discharge", 32'h1, {31'h0, row_negative_rail_discharge});
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, LCDPP_CTRL_OFF, 32'h0);
        chk("ctrl reset", {24'h0, LCDPP_CTRL_RESET}, rd);
        chk("no error", 32'h0, {31'h0, err});
        for (int s = 0; s < 16; s += 5) measure(s[3:0], 1'b1, 1'b1);
        measure(4'h1, 1'b0, 1'b0);
        apb(1'b1, LCDPP_CTRL_OFF, 32'h1);
        measure(4'h0, 1'b1, 1'b0);
        apb(1'b1, LCDPP_CTRL_OFF, 32'h0);
        measure(4'h3, 1'b1, 1'b1);
        // override interval 5 must win over the pins
        apb(1'b1, LCDPP_CTRL_OFF, 32'h52);
        interval_select <= 4'h0;
        f1 = flips;
        while (flips < f1 + 2) @(posedge pclk);
        chk("override lines", 32'h7, seen_lines);
        apb(1'b0, LCDPP_STATUS_OFF, 32'h0);
        chk("override status", 32'h7, {27'h0, rd[12:8]});
        apb(1'b1, LCDPP_CTRL_OFF, 32'h0);
        $display("test override done");
        // controller goes quiet: watchdog flag, then counters are stable to read
        run <= 1'b0;
        repeat (80) @(posedge pclk);
        apb(1'b0, LCDPP_STATUS_OFF, 32'h0);
        chk("line lost", 32'h1, {31'h0, rd[LCDPP_ST_LINE_LOST]});
        apb(1'b0, LCDPP_FLIPS_OFF, 32'h0);
        chk("flip count", flips, rd);
        apb(1'b0, LCDPP_LINES_OFF, 32'h0);
        chk("line count", lines_total, rd);
        apb(1'b1, LCDPP_STATUS_OFF, 32'h10);
        apb(1'b0, LCDPP_STATUS_OFF, 32'h0);
        chk("lost cleared", 32'h0, {31'h0, rd[LCDPP_ST_LINE_LOST]});
        run <= 1'b1;
        $display("test line loss done");
        for (int m = 0; m < 2; m++) begin
            pump_mode_select <= m[0];
            repeat (2) @(posedge pclk);
            chk("mode 6x", {31'h0, m[0]}, {31'h0, pump_mode_6x});
            apb(1'b0, LCDPP_STATUS_OFF, 32'h0);
            chk("status mode", {31'h0, m[0]}, {31'h0, rd[LCDPP_ST_MODE_6X]});
        end
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, LCDPP_LINES_OFF, 32'h5);
        chk("read only error", 32'h1, {31'h0, err});
        apb(1'b1, LCDPP_CTRL_OFF, 32'hFFFFFFFF);
        apb(1'b0, LCDPP_CTRL_OFF, 32'h0);
        chk("ctrl mask", {24'h0, LCDPP_CTRL_MASK}, rd);
        // lane 0 strobe off: write must be ignored
        pstrb <= 4'h0;
        apb(1'b1, LCDPP_CTRL_OFF, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, LCDPP_CTRL_OFF, 32'h0);
        chk("ctrl strobe off", {24'h0, LCDPP_CTRL_MASK}, rd);
        // second reset in mid run must clear the control register
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("mid reset polarity", 32'h0, {31'h0, polarity_out});
        chk("mid reset discharge", 32'h1, {31'h0, row_negative_rail_discharge});
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, LCDPP_CTRL_OFF, 32'h0);
        chk("ctrl after reset", {24'h0, LCDPP_CTRL_RESET}, rd);
        $display("test registers done");
        tally_and_finish();
    end
endmodule : tb_lcdpp_top
